// ==== src/bioce_cfg.svh ====
`ifndef BIOCE_CFG_SVH
`define BIOCE_CFG_SVH
// command codes on the command port
`define BIOCE_OP_OUT_VALUE 4'h1
`define BIOCE_OP_OUT_PATTERN 4'h2
`define BIOCE_OP_IN_PATTERN 4'h3
`define BIOCE_OP_POS_TEST 4'h4
`define BIOCE_OP_POS_LIMIT 4'h5
`define BIOCE_OP_CHANGE_DATA 4'h6
`define BIOCE_OP_COPY_IO 4'h7
`define BIOCE_OP_ZERO_AXIS 4'h8
// pattern codes
`define BIOCE_PAT_OFF 2'h0
`define BIOCE_PAT_ON 2'h1
`define BIOCE_PAT_IGNORE 2'h2
// change operations and types
`define BIOCE_CHG_ADD 2'h0
`define BIOCE_CHG_POS 2'h1
`define BIOCE_CHG_NEG 2'h2
`define BIOCE_CHG_OVR 2'h3
`define BIOCE_TYPE_FIRST 2'h1
`define BIOCE_TYPE_SECOND 2'h2
// copy sources
`define BIOCE_SRC_AUX_IN 2'h0
`define BIOCE_SRC_AUX_OUT 2'h1
`define BIOCE_SRC_SYS_IN 2'h2
`define BIOCE_SRC_SYS_OUT 2'h3
// encoder settings
`define BIOCE_ENC_INCR 2'h1
`define BIOCE_ENC_ABS 2'h2
// ranges
`define BIOCE_OUT_FIRST_MAX 7'h63
`define BIOCE_CPY_SRC_MAX 7'h5A
`define BIOCE_CPY_DST_MAX 7'h50
`define BIOCE_CPY_CNT_MAX 4'h9
`define BIOCE_BANK_MAX 4'h9
`endif

// ==== src/bioce_pkg.sv ====
package bioce_pkg;
    typedef enum logic [1:0] {BIOCE_IDLE, BIOCE_EVAL, BIOCE_WAIT_LOCK, BIOCE_DONE} bioce_state_t;
endpackage : bioce_pkg

// ==== src/bioce_pat_if.sv ====
`timescale 1ns/100ps
// pattern check request and verdict between top and matcher
interface bioce_pat_if;
    logic [9:0] bits;
    logic [19:0] codes;
    logic match;
    modport host (output bits, output codes, input match);
    modport matcher (input bits, input codes, output match);
endinterface : bioce_pat_if

// ==== src/bioce_pat_match.sv ====
`timescale 1ns/100ps
`include "bioce_cfg.svh"
// ten-point pattern compare, purely combinational
module bioce_pat_match (
    bioce_pat_if.matcher pat
);
    logic [9:0] ok;
    // one comparator per point; an illegal code never matches
    genvar g;
    generate
        for (g = 0; g < 10; g++) begin : g_pt
            always_comb begin
                unique case (pat.codes[2*g +: 2])
                    `BIOCE_PAT_OFF: ok[g] = ~pat.bits[g];
                    `BIOCE_PAT_ON: ok[g] = pat.bits[g];
                    `BIOCE_PAT_IGNORE: ok[g] = 1'b1;
                    default: ok[g] = 1'b0;
                endcase
            end
        end
    endgenerate
    assign pat.match = &ok;
endmodule : bioce_pat_match

// ==== src/bioce_pos_cmp.sv ====
`timescale 1ns/100ps
// position window and limit compare on scaled values
module bioce_pos_cmp #(
    parameter int W = 32
) (
    input wire logic signed [W-1:0] act_i,
    input wire logic signed [W-1:0] tgt_i,
    input wire logic signed [W-1:0] prog_i,
    input wire logic [W-1:0] tol_i,
    input wire logic three_dec_i,
    output logic in_window_o,
    output logic at_limit_o
);
    logic signed [W+3:0] prog_s;
    logic signed [W+3:0] diff;
    // programmed value with two places is scaled to thousandths
    always_comb begin
        prog_s = three_dec_i ? (W+4)'(prog_i) : (W+4)'(prog_i) * (W+4)'(10);
        diff = (W+4)'(act_i) - prog_s;
        if (diff < 0) begin
            diff = -diff;
        end
        in_window_o = diff <= $signed({4'h0, tol_i});
        at_limit_o = ((W+4)'(act_i) >= prog_s) || ((W+4)'(tgt_i) >= prog_s);
    end
endmodule : bioce_pos_cmp

// ==== src/bioce_top.sv ====
`timescale 1ns/100ps
`include "bioce_cfg.svh"
// Function
// - target equals offset plus value times length
// - consecutive outputs weighted 1 up to 128
// - first output selectable 01 through 99
// - output pattern codes off, on, ignore
// - output pattern jumps only on full match
// - input pattern codes off, on, ignore
// - input pattern jumps only on full match
// - position test jumps within tolerance
// - position test only scanned after homing
// - limit jumps when actual or target reaches
// - limit branch only scanned after homing
// - positions use two or three decimals
// - type code picks first or second variable
// - operation add, positive, negative, overwrite
// - plus adds, minus subtracts change amount
// - change always advances to next block
// - single-variable targets ignore type code
// - one store change at a time
// - copy source code picks bank
// - copy one to nine consecutive points
// - axis clear loads zero plus offset
// - axis clear needs known encoder
module bioce_top #(
    parameter int W = 32,
    parameter int BLK_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // command from the sequencer
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_op_i,
    input wire logic [BLK_W-1:0] cur_block_i,
    input wire logic [BLK_W-1:0] cmd_target_i,
    input wire logic [BLK_W-1:0] cmd_length_i,
    input wire logic [6:0] cmd_first_i,
    input wire logic [6:0] cmd_second_i,
    input wire logic [3:0] cmd_count_i,
    input wire logic [19:0] cmd_codes_i,
    input wire logic [1:0] cmd_axis_i,
    input wire logic signed [W-1:0] cmd_value_i,
    input wire logic [1:0] cmd_type_i,
    input wire logic [1:0] cmd_chg_op_i,
    input wire logic cmd_minus_i,
    // program store view of the destination block
    input wire logic dst_valid_i,
    input wire logic dst_single_var_i,
    input wire logic signed [W-1:0] dst_var1_i,
    input wire logic signed [W-1:0] dst_var2_i,
    // shared lock for change, transfer and write commands
    input wire logic lock_busy_i,
    // i/o banks, point n at bit n
    input wire logic [99:0] aux_in_i,
    input wire logic [99:0] aux_out_i,
    input wire logic [99:0] sys_in_i,
    input wire logic [99:0] sys_out_i,
    // axis state and settings, four axes packed
    input wire logic [4*W-1:0] act_pos_i,
    input wire logic [4*W-1:0] tgt_pos_i,
    input wire logic [3:0] homed_i,
    input wire logic [4*W-1:0] switching_tolerance_i,
    input wire logic [7:0] encoder_type_setting_i,
    input wire logic [4*W-1:0] position_offset_setting_i,
    input wire logic decimal_places_setting_i,
    // results
    output logic done_o,
    output logic [BLK_W-1:0] next_block_o,
    output logic illegal_cmd_o,
    output logic lock_hold_o,
    output logic dst_we_o,
    output logic dst_sel2_o,
    output logic signed [W-1:0] dst_wdata_o,
    output logic out_we_o,
    output logic [99:0] out_mask_o,
    output logic [99:0] out_data_o,
    output logic axis_we_o,
    output logic [1:0] axis_sel_o,
    output logic signed [W-1:0] axis_wdata_o,
    output logic [3:0] homed_set_o
);
    // ****************
    // state record
    // ****************
    typedef struct packed {
        bioce_pkg::bioce_state_t st;
        logic done;
        logic [BLK_W-1:0] next_block;
        logic illegal;
        logic lock_hold;
        logic dst_we;
        logic dst_sel2;
        logic [W-1:0] dst_wdata;
        logic out_we;
        logic [99:0] out_mask;
        logic [99:0] out_data;
        logic axis_we;
        logic [1:0] axis_sel;
        logic [W-1:0] axis_wdata;
        logic [3:0] homed_set;
    } bioce_regs_t;

    bioce_regs_t r;
    bioce_regs_t next_r;

    // ****************
    // helpers
    // ****************
    bioce_pat_if pat ();
    logic [99:0] bank_src;
    logic [6:0] bank_base;
    logic signed [W-1:0] ax_act;
    logic signed [W-1:0] ax_tgt;
    logic [W-1:0] ax_tol;
    logic [1:0] ax_enc;
    logic in_window;
    logic at_limit;
    logic [7:0] out_value;
    logic [99:0] src_bank;
    logic [99:0] cpy_mask;
    logic [99:0] cpy_data;
    logic signed [W:0] chg_sum;
    logic signed [W-1:0] chg_old;

    // per-axis fields; axis 1..4 arrives as 0..3
    assign ax_act = act_pos_i[cmd_axis_i*W +: W];
    assign ax_tgt = tgt_pos_i[cmd_axis_i*W +: W];
    assign ax_tol = switching_tolerance_i[cmd_axis_i*W +: W];
    assign ax_enc = encoder_type_setting_i[cmd_axis_i*2 +: 2];

    // pattern bank: points 10*bank .. 10*bank+9
    always_comb begin
        bank_base = 7'(cmd_first_i[3:0]) * 7'hA;
        bank_src = (cmd_op_i == `BIOCE_OP_IN_PATTERN) ? aux_in_i : aux_out_i;
    end
    assign pat.bits = bank_src[bank_base +: 10];
    assign pat.codes = cmd_codes_i;

    bioce_pat_match u_pat (
        .pat(pat)
    );

    bioce_pos_cmp #(.W(W)) u_pos (
        .act_i(ax_act),
        .tgt_i(ax_tgt),
        .prog_i(cmd_value_i),
        .tol_i(ax_tol),
        .three_dec_i(decimal_places_setting_i),
        .in_window_o(in_window),
        .at_limit_o(at_limit)
    );

    // first output weight 1, doubling per output
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_val
            assign out_value[g] = (4'(g) < cmd_count_i) ? aux_out_i[cmd_first_i + 7'(g)] : 1'b0;
        end
    endgenerate

    // copy source bank and destination window
    always_comb begin
        unique case (cmd_type_i)
            `BIOCE_SRC_AUX_IN: src_bank = aux_in_i;
            `BIOCE_SRC_AUX_OUT: src_bank = aux_out_i;
            `BIOCE_SRC_SYS_IN: src_bank = sys_in_i;
            `BIOCE_SRC_SYS_OUT: src_bank = sys_out_i;
        endcase
        cpy_mask = '0;
        cpy_data = '0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < cmd_count_i) begin
                cpy_mask[cmd_second_i + 7'(i)] = 1'b1;
                cpy_data[cmd_second_i + 7'(i)] = src_bank[cmd_first_i + 7'(i)];
            end
        end
    end

    // change amount applied to the selected variable
    always_comb begin
        chg_old = (dst_single_var_i || cmd_type_i == `BIOCE_TYPE_FIRST) ? dst_var1_i : dst_var2_i;
        chg_sum = cmd_minus_i ? ((W+1)'(chg_old) - (W+1)'(cmd_value_i))
                              : ((W+1)'(chg_old) + (W+1)'(cmd_value_i));
    end

    // ****************
    // next state
    // ****************
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.dst_we = 1'b0;
        next_r.out_we = 1'b0;
        next_r.axis_we = 1'b0;
        next_r.homed_set = 4'h0;
        next_r.illegal = 1'b0;
        unique case (r.st)
            bioce_pkg::BIOCE_IDLE: begin
                if (cmd_valid_i) begin
                    next_r.st = bioce_pkg::BIOCE_EVAL;
                end
            end
            bioce_pkg::BIOCE_EVAL, bioce_pkg::BIOCE_WAIT_LOCK: begin
                // default is stepping on to the next block
                next_r.next_block = BLK_W'(cur_block_i + 1'b1);
                next_r.st = bioce_pkg::BIOCE_DONE;
                next_r.done = 1'b1;
                unique case (cmd_op_i)
                    `BIOCE_OP_OUT_VALUE: begin
                        if (cmd_first_i >= 7'h01 && cmd_first_i <= `BIOCE_OUT_FIRST_MAX) begin
                            next_r.next_block = BLK_W'(cmd_target_i + cmd_length_i * BLK_W'(out_value));
                        end else begin
                            next_r.illegal = 1'b1;
                        end
                    end
                    `BIOCE_OP_OUT_PATTERN, `BIOCE_OP_IN_PATTERN: begin
                        if (cmd_first_i[3:0] > `BIOCE_BANK_MAX) begin
                            next_r.illegal = 1'b1;
                        end else if (pat.match) begin
                            next_r.next_block = cmd_target_i;
                        end
                    end
                    `BIOCE_OP_POS_TEST: begin
                        if (homed_i[cmd_axis_i] && in_window) begin
                            next_r.next_block = cmd_target_i;
                        end
                    end
                    `BIOCE_OP_POS_LIMIT: begin
                        if (homed_i[cmd_axis_i] && at_limit) begin
                            next_r.next_block = cmd_target_i;
                        end
                    end
                    `BIOCE_OP_CHANGE_DATA: begin
                        if (lock_busy_i && !r.lock_hold) begin
                            // another task owns the store; hold the command
                            next_r.st = bioce_pkg::BIOCE_WAIT_LOCK;
                            next_r.done = 1'b0;
                        end else if (dst_valid_i) begin
                            next_r.dst_sel2 = !dst_single_var_i && cmd_type_i == `BIOCE_TYPE_SECOND;
                            unique case (cmd_chg_op_i)
                                `BIOCE_CHG_ADD: begin
                                    next_r.dst_we = 1'b1;
                                    next_r.dst_wdata = W'(chg_sum);
                                end
                                `BIOCE_CHG_POS: begin
                                    next_r.dst_we = !chg_sum[W] && chg_sum != '0;
                                    next_r.dst_wdata = W'(chg_sum);
                                end
                                `BIOCE_CHG_NEG: begin
                                    next_r.dst_we = chg_sum[W];
                                    next_r.dst_wdata = W'(chg_sum);
                                end
                                `BIOCE_CHG_OVR: begin
                                    next_r.dst_we = 1'b1;
                                    next_r.dst_wdata = cmd_minus_i ? W'(-cmd_value_i) : cmd_value_i;
                                end
                            endcase
                        end
                    end
                    `BIOCE_OP_COPY_IO: begin
                        if (cmd_count_i == 4'h0 || cmd_count_i > `BIOCE_CPY_CNT_MAX
                            || cmd_first_i == 7'h00 || cmd_first_i > `BIOCE_CPY_SRC_MAX
                            || cmd_second_i == 7'h00 || cmd_second_i > `BIOCE_CPY_DST_MAX) begin
                            next_r.illegal = 1'b1;
                        end else begin
                            next_r.out_we = 1'b1;
                            next_r.out_mask = cpy_mask;
                            next_r.out_data = cpy_data;
                        end
                    end
                    `BIOCE_OP_ZERO_AXIS: begin
                        if (ax_enc == `BIOCE_ENC_INCR || ax_enc == `BIOCE_ENC_ABS) begin
                            next_r.axis_we = 1'b1;
                            next_r.axis_sel = cmd_axis_i;
                            next_r.axis_wdata = position_offset_setting_i[cmd_axis_i*W +: W];
                            // incremental encoders become homed
                            if (ax_enc == `BIOCE_ENC_INCR) begin
                                next_r.homed_set[cmd_axis_i] = 1'b1;
                            end
                        end else begin
                            next_r.illegal = 1'b1;
                        end
                    end
                    default: begin
                        next_r.illegal = 1'b1;
                    end
                endcase
                // lock held only over the store write
                next_r.lock_hold = (cmd_op_i == `BIOCE_OP_CHANGE_DATA) && next_r.done;
            end
            bioce_pkg::BIOCE_DONE: begin
                // wait for the sequencer to drop its request
                next_r.lock_hold = 1'b0;
                if (!cmd_valid_i) begin
                    next_r.st = bioce_pkg::BIOCE_IDLE;
                end
            end
        endcase
    end

    // ****************
    // registers
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= bioce_pkg::BIOCE_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign done_o = r.done;
    assign next_block_o = r.next_block;
    assign illegal_cmd_o = r.illegal;
    assign lock_hold_o = r.lock_hold;
    assign dst_we_o = r.dst_we;
    assign dst_sel2_o = r.dst_sel2;
    assign dst_wdata_o = r.dst_wdata;
    assign out_we_o = r.out_we;
    assign out_mask_o = r.out_mask;
    assign out_data_o = r.out_data;
    assign axis_we_o = r.axis_we;
    assign axis_sel_o = r.axis_sel;
    assign axis_wdata_o = r.axis_wdata;
    assign homed_set_o = r.homed_set;
endmodule : bioce_top

// ==== testbench/bioce_top_asserts.sv ====
`timescale 1ns/100ps
`include "bioce_cfg.svh"
// ****************
// port checker
// ****************
module bioce_top_asserts #(
    parameter int W = 32,
    parameter int BLK_W = 12
) (
    input logic clk_i,
    input logic rst_i,
    input logic cmd_valid_i,
    input logic [3:0] cmd_op_i,
    input logic [BLK_W-1:0] cur_block_i,
    input logic [3:0] cmd_count_i,
    input logic [1:0] cmd_axis_i,
    input logic [1:0] cmd_type_i,
    input logic dst_single_var_i,
    input logic lock_busy_i,
    input logic [3:0] homed_i,
    input logic [7:0] encoder_type_setting_i,
    input logic [4*W-1:0] position_offset_setting_i,
    input logic done_o,
    input logic [BLK_W-1:0] next_block_o,
    input logic illegal_cmd_o,
    input logic dst_we_o,
    input logic dst_sel2_o,
    input logic out_we_o,
    input logic [99:0] out_mask_o,
    input logic axis_we_o,
    input logic [1:0] axis_sel_o,
    input logic signed [W-1:0] axis_wdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a finished command always had its request held for two edges
    a_done_held: assert property (done_o |-> $past(cmd_valid_i, 1) && $past(cmd_valid_i, 2))
        else $error("done without held request");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_illegal_step: assert property (illegal_cmd_o |-> done_o && next_block_o == cur_block_i + 1'b1)
        else $error("illegal without step");
    // unhomed tests only step on
    a_unhomed_scan: assert property (done_o && !homed_i[cmd_axis_i] && cmd_op_i inside {`BIOCE_OP_POS_TEST,
        `BIOCE_OP_POS_LIMIT} |-> next_block_o == cur_block_i + 1'b1 && !illegal_cmd_o)
        else $error("unhomed test executed");
    a_zero_offset: assert property (axis_we_o |-> axis_sel_o == cmd_axis_i
        && axis_wdata_o == position_offset_setting_i[axis_sel_o*W +: W])
        else $error("axis zero value wrong");
    a_zero_refuse: assert property (done_o && cmd_op_i == `BIOCE_OP_ZERO_AXIS |-> illegal_cmd_o != (axis_we_o
        && encoder_type_setting_i[2*cmd_axis_i +: 2] inside {`BIOCE_ENC_INCR, `BIOCE_ENC_ABS}))
        else $error("axis zero encoder check wrong");
    // a write follows an evaluation with the lock free
    a_lock_wait: assert property (dst_we_o |-> !$past(lock_busy_i))
        else $error("change written while locked");
    a_dst_select: assert property (dst_we_o |-> dst_sel2_o == (!dst_single_var_i
        && cmd_type_i == `BIOCE_TYPE_SECOND))
        else $error("wrong variable selected");
    a_copy_count: assert property (out_we_o && cmd_op_i == `BIOCE_OP_COPY_IO
        |-> $countones(out_mask_o) == cmd_count_i)
        else $error("copy count wrong");
    c_illegal: cover property (illegal_cmd_o);
    c_change: cover property (dst_we_o && dst_sel2_o);
    c_copy: cover property (out_we_o);
    c_zero: cover property (axis_we_o);
endmodule : bioce_top_asserts
bind bioce_top bioce_top_asserts #(.W(W), .BLK_W(BLK_W)) i_bioce_top_asserts (.*);

// ==== testbench/bioce_io_model.sv ====
`timescale 1ns/100ps
// ****************
// program store, output bank and axis registers
// ****************
module bioce_io_model #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic dst_we_i,
    input wire logic dst_sel2_i,
    input wire logic signed [W-1:0] dst_wdata_i,
    input wire logic out_we_i,
    input wire logic [99:0] out_mask_i,
    input wire logic [99:0] out_data_i,
    input wire logic axis_we_i,
    input wire logic [1:0] axis_sel_i,
    input wire logic signed [W-1:0] axis_wdata_i,
    output logic [99:0] aux_out_o,
    output logic signed [W-1:0] var1_o,
    output logic signed [W-1:0] var2_o,
    output logic [4*W-1:0] act_pos_o
);
    // zeroed at start, preloaded by the bench
    initial begin
        aux_out_o = 100'h0;
        var1_o = 32'sh0;
        var2_o = 32'sh0;
        act_pos_o = 128'h0;
    end
    // commits land on the edge after the pulse
    always @(posedge clk_i) begin
        if (out_we_i) begin
            aux_out_o <= (aux_out_o & ~out_mask_i) | (out_data_i & out_mask_i);
        end
        if (dst_we_i && dst_sel2_i) begin
            var2_o <= dst_wdata_i;
        end else if (dst_we_i) begin
            var1_o <= dst_wdata_i;
        end
        if (axis_we_i) begin
            act_pos_o[axis_sel_i*W +: W] <= axis_wdata_i;
        end
    end
endmodule : bioce_io_model

// ==== testbench/bioce_top_bench.sv ====
`timescale 1ns/100ps
`include "bioce_cfg.svh"
module bioce_top_bench;
    localparam int W = 32;
    // ****************
    // stimulus and observed signals
    // ****************
    logic clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_minus_i = 1'b0, lock_busy_i = 1'b0;
    logic dst_valid_i = 1'b1, dst_single_var_i = 1'b0, decimal_places_setting_i = 1'b1;
    logic [3:0] cmd_op_i = 4'h0, cmd_count_i = 4'h0, homed_i = 4'hF, homed_set_o, hs;
    logic [11:0] cur_block_i = 12'h010, cmd_target_i = 12'h064, cmd_length_i = 12'h002, next_block_o, blk;
    logic [6:0] cmd_first_i = 7'h05, cmd_second_i = 7'h50;
    logic [19:0] cmd_codes_i = 20'hA0055;
    logic [1:0] cmd_axis_i = 2'h0, cmd_type_i = 2'h1, cmd_chg_op_i = 2'h0, axis_sel_o;
    logic [7:0] encoder_type_setting_i = 8'h24;
    logic signed [W-1:0] cmd_value_i = 32'sh0, dst_var1_i, dst_var2_i, dst_wdata_o, axis_wdata_o;
    logic [99:0] aux_in_i = 100'h0, sys_in_i = 100'h0, sys_out_i = 100'h0, aux_out_i, out_mask_o, out_data_o;
    logic [4*W-1:0] act_pos_i, tgt_pos_i = 128'h0, switching_tolerance_i = {4{32'hA}};
    logic [4*W-1:0] position_offset_setting_i = {32'hFA0, 32'hBB8, 32'h7D0, 32'h3E8};
    logic done_o, illegal_cmd_o, lock_hold_o, dst_we_o, dst_sel2_o, out_we_o, axis_we_o, ill, lh;
    logic [8:0] pat [4] = '{9'h1A5, 9'h05A, 9'h133, 9'h0CC};
    int num_errors = 0, checks = 0, cyc = 0, lat;
    bioce_top #(.W(W), .BLK_W(12)) i_bioce_top (.*);
    bioce_io_model #(.W(W)) i_bioce_io_model (.clk_i(clk_i), .dst_we_i(dst_we_o), .dst_sel2_i(dst_sel2_o),
        .dst_wdata_i(dst_wdata_o), .out_we_i(out_we_o), .out_mask_i(out_mask_o), .out_data_i(out_data_o),
        .axis_we_i(axis_we_o), .axis_sel_i(axis_sel_o), .axis_wdata_i(axis_wdata_o), .aux_out_o(aux_out_i),
        .var1_o(dst_var1_i), .var2_o(dst_var2_i), .act_pos_o(act_pos_i));
    always #20 clk_i = ~clk_i;
    // hang guard, the whole run needs about a hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic chk_blk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_blk
    task automatic chk_dat(input string what, input logic [99:0] exp, input logic [99:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_dat
    // request held until done is seen, then dropped for one cycle
    task automatic run(input logic [3:0] op, input int hold);
        lat = 0;
        cmd_op_i = op;
        cmd_valid_i = 1'b1;
        do begin
            @(negedge clk_i);
            lat++;
            if (lat == hold) lock_busy_i = 1'b0;
        end while (done_o !== 1'b1 && lat < 40);
        blk = next_block_o;
        ill = illegal_cmd_o;
        lh = lock_hold_o;
        hs = homed_set_o;
        cmd_valid_i = 1'b0;
        @(negedge clk_i);
    endtask : run
    task automatic br(input logic [3:0] op, input logic [11:0] exp);
        run(op, 0);
        chk_blk("next block", exp, blk);
    endtask : br
    task automatic chg(input logic [1:0] ty, input logic [1:0] op, input logic mi, input logic signed [W-1:0] v,
                       input logic signed [W-1:0] e1, input logic signed [W-1:0] e2, input int hold);
        cmd_type_i = ty;
        cmd_chg_op_i = op;
        cmd_minus_i = mi;
        cmd_value_i = v;
        run(`BIOCE_OP_CHANGE_DATA, hold);
        chk_blk("change next", 12'h011, blk);
        chk_dat("first var", e1, dst_var1_i);
        chk_dat("second var", e2, dst_var2_i);
    endtask : chg
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ****************
    // tests
    // ****************
    initial begin
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        chk_blk("next after reset", 12'h000, next_block_o);
        i_bioce_io_model.aux_out_o = 100'h33 << 5;
        cmd_count_i = 4'h8;
        br(`BIOCE_OP_OUT_VALUE, 12'h0CA);
        i_bioce_io_model.aux_out_o = 100'h1 << 99;
        cmd_first_i = 7'h63;
        cmd_count_i = 4'h1;
        cmd_length_i = 12'h007;
        br(`BIOCE_OP_OUT_VALUE, 12'h06B);
        $display("test output value finished");
        // bank two: ignored point may differ, an off point may not
        i_bioce_io_model.aux_out_o = 100'h00F << 20;
        cmd_first_i = 7'h02;
        br(`BIOCE_OP_OUT_PATTERN, 12'h064);
        i_bioce_io_model.aux_out_o[28] = 1'b1;
        br(`BIOCE_OP_OUT_PATTERN, 12'h064);
        i_bioce_io_model.aux_out_o[24] = 1'b1;
        br(`BIOCE_OP_OUT_PATTERN, 12'h011);
        aux_in_i = 100'h00F;
        cmd_first_i = 7'h00;
        br(`BIOCE_OP_IN_PATTERN, 12'h064);
        aux_in_i[3] = 1'b0;
        br(`BIOCE_OP_IN_PATTERN, 12'h011);
        $display("test patterns finished");
        cmd_axis_i = 2'h1;
        i_bioce_io_model.act_pos_o[W +: W] = 32'h3039;
        cmd_value_i = 32'sh303E;
        br(`BIOCE_OP_POS_TEST, 12'h064);
        cmd_value_i = 32'sh3044;
        br(`BIOCE_OP_POS_TEST, 12'h011);
        decimal_places_setting_i = 1'b0;
        cmd_value_i = 32'sh4D3;
        br(`BIOCE_OP_POS_TEST, 12'h064);
        cmd_value_i = 32'sh4D5;
        br(`BIOCE_OP_POS_TEST, 12'h011);
        decimal_places_setting_i = 1'b1;
        homed_i = 4'hD;
        cmd_value_i = 32'sh3039;
        br(`BIOCE_OP_POS_TEST, 12'h011);
        cmd_value_i = 32'sh1F4;
        br(`BIOCE_OP_POS_LIMIT, 12'h011);
        homed_i = 4'hF;
        cmd_axis_i = 2'h2;
        i_bioce_io_model.act_pos_o[2*W +: W] = 32'h64;
        tgt_pos_i[2*W +: W] = 32'h1F4;
        br(`BIOCE_OP_POS_LIMIT, 12'h064);
        cmd_value_i = 32'sh1F5;
        br(`BIOCE_OP_POS_LIMIT, 12'h011);
        i_bioce_io_model.act_pos_o[2*W +: W] = 32'h258;
        br(`BIOCE_OP_POS_LIMIT, 12'h064);
        $display("test positions finished");
        i_bioce_io_model.var1_o = 32'sh64;
        i_bioce_io_model.var2_o = 32'sh32;
        chg(2'h1, `BIOCE_CHG_ADD, 1'b0, 32'sh07, 32'sh6B, 32'sh32, 0);
        chk_dat("lock hold", 100'h1, lh);
        chg(2'h2, `BIOCE_CHG_ADD, 1'b1, 32'sh3C, 32'sh6B, -32'sh0A, 0);
        chg(2'h2, `BIOCE_CHG_POS, 1'b0, 32'sh05, 32'sh6B, -32'sh0A, 0);
        chg(2'h2, `BIOCE_CHG_NEG, 1'b0, 32'sh05, 32'sh6B, -32'sh05, 0);
        chg(2'h1, `BIOCE_CHG_OVR, 1'b0, 32'sh21, 32'sh21, -32'sh05, 0);
        dst_valid_i = 1'b0;
        chg(2'h1, `BIOCE_CHG_ADD, 1'b0, 32'sh01, 32'sh21, -32'sh05, 0);
        dst_valid_i = 1'b1;
        dst_single_var_i = 1'b1;
        chg(2'h2, `BIOCE_CHG_ADD, 1'b0, 32'sh02, 32'sh23, -32'sh05, 0);
        dst_single_var_i = 1'b0;
        lock_busy_i = 1'b1;
        chg(2'h1, `BIOCE_CHG_ADD, 1'b0, 32'sh01, 32'sh24, -32'sh05, 6);
        chk_dat("lock wait", 100'h1, lat > 6);
        $display("test change data finished");
        // each source bank has its own pattern at 90..98
        aux_in_i = 100'h1A5 << 90;
        i_bioce_io_model.aux_out_o = 100'h05A << 90;
        sys_in_i = 100'h133 << 90;
        sys_out_i = 100'h0CC << 90;
        cmd_first_i = 7'h5A;
        cmd_count_i = 4'h9;
        for (int s = 0; s < 4; s++) begin
            cmd_type_i = s[1:0];
            run(`BIOCE_OP_COPY_IO, 0);
            chk_dat("copied points", {1'b0, pat[s], 1'b0}, aux_out_i[89:79]);
        end
        $display("test copy finished");
        i_bioce_io_model.act_pos_o[3*W +: W] = 32'h55;
        for (int a = 1; a < 4; a++) begin
            cmd_axis_i = a[1:0];
            run(`BIOCE_OP_ZERO_AXIS, 0);
            chk_blk("zero next", 12'h011, blk);
            chk_dat("illegal", a == 3, ill);
            chk_dat("homed set", (a == 1) ? 4'h2 : 4'h0, hs);
            chk_dat("axis pos", (a == 3) ? 32'h55 : position_offset_setting_i[a*W +: W],
                    act_pos_i[a*W +: W]);
        end
        $display("test zero axis finished");
        end_sim();
    end
endmodule : bioce_top_bench
